// file: verilog/ov_trip_defs.vh
// Constants of the overvoltage trip timing stage: timing, defaults, map.
// Assumes a 200 MHz system clock and 5 ms processing cycles.
//
// Summary of operation
// [R1] Blocking input is sampled at each cycle start, before pick-up is evaluated.
// [R2] Pick-up while unblocked raises START and starts operating time calculation.
// [R3] Pick-up while blocked raises BLOCKED instead; no timing is done.
// [R4] Blocking during START drops START and runs release as on pick-up loss; START is held through nonzero release delay if delayed release is on.
// [R5] Blocking must arrive at least 5 ms before the operating delay ends.
// [R6] Instant operation raises TRIP in the same cycle as START.
// [R7] Fixed delay trips after the set delay with pick-up held, voltage ignored.
// [R8] Inverse delay is dial over (voltage ratio to the exponent minus one).
// [R9] Delay type selects fixed or inverse delay; fixed is the default.
// [R10] Fixed delay has 5 ms resolution, default 40 ms, used in fixed mode only.
// [R11] Fixed delay of zero behaves as instant; nonzero gives a delayed trip.
// [R12] Time dial has 0.01 resolution, default 0.05 s, inverse mode only.
// [R13] Inverse exponent has 0.01 resolution and defaults to 1.00.
// [R14] Release delay, 5 ms resolution, default 60 ms, holds START after drop.
// [R15] Delayed release on (default) holds START; off clears START at once.
// [R16] Reset-after-release on (default) clears timer only after full release time.
// [R17] Continue-timing on lets the operating timer advance during release.
// [R18] Time left before TRIP is reported in 5 ms steps while counting.
// [R19] Expected time in inverse mode is recomputed from present voltage.
// [R20] Ratio of voltage to pick-up is reported per phase and supervised value.
// [R21] Pick-up threshold is reported in primary volts with 0.1 V resolution.
// [R22] Pick-up needs one, two or three phases above level, per operation mode.
// [R23] Pick-up drops only below 97 % of the pick-up level.
// [R24] Timers step once per 5 ms cycle; delays are whole cycle counts.
// [R25] Inverse delay is unbounded while the voltage ratio is not above one.
`ifndef OV_TRIP_DEFS_VH
`define OV_TRIP_DEFS_VH

// Timing
`define CLK_PERIOD_NS 5
`define STEP_MS       5
`define CYCLE_CLKS    (`STEP_MS * 1000000 / `CLK_PERIOD_NS)
`define DT_DEF_MS     40
`define REL_DEF_MS    60
`define DIAL_UNIT_MS  10
`define DIAL_CYC      17'h00002

// Setting defaults (level units 0.01 % of nominal)
`define CTRL_DEF      6'h16
`define USET_DEF      16'h2904
`define DT_DEF        20'h00008
`define REL_DEF       16'h000c
`define DIAL_DEF      16'h0005
`define EXPON_DEF     16'h0064
`define UN_PRIM_DEF   16'h4e20
`define HYST_PCT      8'h61
`define PCT_FULL      8'h64
`define PRIM_DIV      32'h000003e8
`define POW_SCALE     6'h29

// Control bits
`define C_INV         0
`define C_DLYREL      1
`define C_RSTAFT      2
`define C_CONT        3
`define C_MODE_LO     4
`define C_MODE_HI     5

// Register offsets
`define A_CTRL        4'h0
`define A_USET        4'h1
`define A_DT          4'h2
`define A_DIAL        4'h3
`define A_EXPON       4'h4
`define A_REL         4'h5
`define A_UNPRIM      4'h6
`define A_STATUS      4'h8
`define A_EXPECT      4'h9
`define A_REMAIN      4'ha
`define A_RATIO0      4'hb
`define A_PRIM        4'hf

`endif

// file: verilog/overvoltage_trip_timing.v
// Trip and release timing of one overvoltage stage with its register port.
// Assumes measured values and pick-up level share units of 0.01 % nominal,
// arrive on this clock, and that the blocking input comes from a pin.
`timescale 1ns/1ps
`include "ov_trip_defs.vh"

module overvoltage_trip_timing #(
   parameter integer CYCLE_CLKS = `CYCLE_CLKS
) (
   // Clock and reset
   input  wire        clk_sys_i,
   input  wire        reset_i,
   // Register port
   input  wire [3:0]  reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [31:0] reg_rdata_o,
   // Measurement front end
   input  wire [15:0] meas_a_i,
   input  wire [15:0] meas_b_i,
   input  wire [15:0] meas_c_i,
   input  wire [15:0] meas_s_i,
   // Blocking matrix
   input  wire        block_i,
   // Stage outputs
   output reg         start_o,
   output reg         trip_o,
   output reg         blocked_o
);

   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_RUN  = 5'h02;
   localparam [4:0] ST_REL  = 5'h04;
   localparam [4:0] ST_TRIP = 5'h08;
   localparam [4:0] ST_BLK  = 5'h10;
   localparam [2:0] J_INV   = 3'h4;
   localparam [2:0] J_LAST  = 3'h5;
   localparam [19:0] TICK_LAST = CYCLE_CLKS[19:0] - 20'h00001;
   localparam [19:0] CNT_MAX   = 20'hfffff;

   integer i;
   integer k;

   // Settings
   reg  [5:0]  ctrl_q;
   reg  [15:0] uset_q;
   reg  [19:0] dt_q;
   reg  [15:0] dial_q;
   reg  [15:0] expon_q;
   reg  [15:0] rel_q;
   reg  [15:0] unprim_q;

   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         ctrl_q   <= `CTRL_DEF;                  // R9
         uset_q   <= `USET_DEF;
         dt_q     <= `DT_DEF;                    // R10
         dial_q   <= `DIAL_DEF;                  // R12
         expon_q  <= `EXPON_DEF;                 // R13
         rel_q    <= `REL_DEF;                   // R14
         unprim_q <= `UN_PRIM_DEF;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `A_CTRL:   ctrl_q   <= reg_wdata_i[5:0];
            `A_USET:   uset_q   <= reg_wdata_i[15:0];
            `A_DT:     dt_q     <= reg_wdata_i[19:0];
            `A_DIAL:   dial_q   <= reg_wdata_i[15:0];
            `A_EXPON:  expon_q  <= reg_wdata_i[15:0];
            `A_REL:    rel_q    <= reg_wdata_i[15:0];
            `A_UNPRIM: unprim_q <= reg_wdata_i[15:0];
            default: ;
         endcase
      end
   end

   wire       inv_mode = ctrl_q[`C_INV];
   wire [1:0] mode     = ctrl_q[`C_MODE_HI:`C_MODE_LO];
   wire [1:0] need_n   = (mode == 2'h0) ? 2'h1 : mode;

   // Processing cycle tick, then evaluation one clock later
   reg [19:0] tick_cnt_q;
   reg        tick_q;
   reg        eval_q;

   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         tick_cnt_q <= 20'h00000;
         tick_q     <= 1'b0;
         eval_q     <= 1'b0;
      end else begin
         eval_q <= tick_q;
         if (tick_cnt_q == TICK_LAST) begin   // R24
            tick_cnt_q <= 20'h00000;
            tick_q     <= 1'b1;
         end else begin
            tick_cnt_q <= tick_cnt_q + 20'h00001;
            tick_q     <= 1'b0;
         end
      end
   end

   // Blocking pin filter; its four clocks (20 ns) are negligible against the lead time
   reg [2:0] blk_sync_q;
   reg       blk_filt_q;
   reg       blk_cyc_q;

   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         blk_sync_q <= 3'h0;
         blk_filt_q <= 1'b0;
         blk_cyc_q  <= 1'b0;
      end else begin
         blk_sync_q <= {blk_sync_q[1:0], block_i};
         if (blk_sync_q[1] == blk_sync_q[2])
            blk_filt_q <= blk_sync_q[2];      // R5
         if (tick_q)
            blk_cyc_q <= blk_filt_q;          // R1
      end
   end

   // Per-phase pick-up with hysteresis
   wire [15:0] meas_w [0:3];
   assign meas_w[0] = meas_a_i;
   assign meas_w[1] = meas_b_i;
   assign meas_w[2] = meas_c_i;
   assign meas_w[3] = meas_s_i;

   wire [23:0] drop_lvl = uset_q * `HYST_PCT;
   wire [2:0]  ph_act;

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_ph
         reg         act_q;
         wire [23:0] m_pct = meas_w[g] * `PCT_FULL;
         always @(posedge clk_sys_i) begin
            if (reset_i)
               act_q <= 1'b0;
            else if (tick_q) begin
               if (meas_w[g] > uset_q)
                  act_q <= 1'b1;
               else if (m_pct < drop_lvl)
                  act_q <= 1'b0;             // R23
            end
         end
         assign ph_act[g] = act_q;
      end
   endgenerate

   wire [1:0] ph_n = {1'b0, ph_act[0]} + {1'b0, ph_act[1]} + {1'b0, ph_act[2]};
   wire       pu   = (ph_n >= need_n);         // R22

   // Shared divider results
   reg [15:0] ratio_q [0:3];
   reg [19:0] inv_t_q;
   reg        inv_inf_q;
   reg [31:0] prim_q;

   // Inverse characteristic: log2, scale by exponent, exp2
   reg [15:0] rmax;
   reg [3:0]  lead;
   reg [15:0] norm;
   always @* begin
      rmax = ratio_q[0];
      if (ratio_q[1] > rmax)
         rmax = ratio_q[1];
      if (ratio_q[2] > rmax)
         rmax = ratio_q[2];
      lead = 4'h0;
      for (i = 0; i < 16; i = i + 1)
         if (rmax[i])
            lead = i[3:0];
      norm = rmax << (4'hf - lead);
   end

   wire [11:0] log_q8  = {lead - 4'h8, norm[14:7]};
   wire [35:0] y_prod  = log_q8 * expon_q * `POW_SCALE;
   wire [23:0] y_q8    = y_prod[35:12];
   wire        y_big   = (y_q8[23:8] > 16'h0017);
   wire [31:0] pow_q8  = {23'h000000, 1'b1, y_q8[7:0]} << y_q8[12:8];
   wire [31:0] den     = y_big ? 32'hffffffff : pow_q8 - 32'h00000100;
   wire        inv_inf = (rmax <= 16'h0100) | (den == 32'h00000000);  // R25
   wire [31:0] inv_dvd = {7'h00, dial_q * `DIAL_CYC, 8'h00};          // R8

   // Sequential divider, one job after another each cycle
   reg        run_q;
   reg [2:0]  job_q;
   reg [4:0]  step_q;
   reg [31:0] quo_q;
   reg [31:0] dvs_q;
   reg [31:0] div_rem_q;
   reg [31:0] ld_dvd;
   reg [31:0] ld_dvs;

   wire [2:0]  job_sel = tick_q ? 3'h0 : job_q + 3'h1;
   wire [32:0] div_sh  = {div_rem_q, quo_q[31]};
   wire        div_ge  = (div_sh >= {1'b0, dvs_q});
   wire [32:0] div_sub = div_sh - {1'b0, dvs_q};
   wire [31:0] quo_n   = {quo_q[30:0], div_ge};
   wire [15:0] quo_sat = (quo_n[31:16] != 16'h0000) ? 16'hffff : quo_n[15:0];

   always @* begin
      case (job_sel)
         J_INV: begin
            ld_dvd = inv_dvd;
            ld_dvs = den;
         end
         J_LAST: begin
            ld_dvd = uset_q * unprim_q;
            ld_dvs = `PRIM_DIV;
         end
         default: begin
            ld_dvd = {8'h00, meas_w[job_sel[1:0]], 8'h00};
            ld_dvs = {16'h0000, uset_q};
         end
      endcase
   end

   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         run_q     <= 1'b0;
         job_q     <= 3'h0;
         step_q    <= 5'h00;
         quo_q     <= 32'h00000000;
         dvs_q     <= 32'h00000000;
         div_rem_q <= 32'h00000000;
         for (k = 0; k < 4; k = k + 1)
            ratio_q[k] <= 16'h0000;
         inv_t_q   <= CNT_MAX;
         inv_inf_q <= 1'b1;
         prim_q    <= 32'h00000000;
      end else if (tick_q || (run_q && step_q == 5'h1f && job_q != J_LAST)) begin
         if (!tick_q) begin
            if (job_q == J_INV) begin
               inv_t_q   <= (quo_n[31:20] != 12'h000) ? CNT_MAX : quo_n[19:0];
               inv_inf_q <= inv_inf;
            end else
               ratio_q[job_q[1:0]] <= quo_sat;  // R20
         end
         run_q     <= 1'b1;
         job_q     <= job_sel;
         step_q    <= 5'h00;
         quo_q     <= ld_dvd;
         dvs_q     <= ld_dvs;
         div_rem_q <= 32'h00000000;
      end else if (run_q) begin
         quo_q     <= quo_n;
         div_rem_q <= div_ge ? div_sub[31:0] : div_sh[31:0];
         step_q    <= step_q + 5'h01;
         if (step_q == 5'h1f) begin
            run_q  <= 1'b0;
            prim_q <= quo_n;                    // R21
         end
      end
   end

   // Trip and release sequence
   reg [4:0]  st_q;
   reg [19:0] op_q;
   reg [15:0] relc_q;
   reg [4:0]  st_d;
   reg [19:0] op_d;
   reg [15:0] relc_d;

   wire        blk     = blk_cyc_q;
   wire [19:0] tgt     = inv_mode ? inv_t_q : dt_q;
   wire        no_tgt  = inv_mode & inv_inf_q;
   wire        instant = !inv_mode && dt_q == 20'h00000;      // R11
   wire [19:0] op_inc  = (op_q == CNT_MAX) ? op_q : op_q + 20'h00001;
   wire        hit     = !no_tgt && op_inc >= tgt;           // R7

   always @* begin
      st_d   = st_q;
      op_d   = op_q;
      relc_d = relc_q;
      if (eval_q) begin
         case (st_q)
            ST_IDLE: begin
               op_d = 20'h00000;
               if (pu && blk)
                  st_d = ST_BLK;                // R3
               else if (pu)
                  st_d = instant ? ST_TRIP : ST_RUN;  // R2 R6
            end
            ST_RUN: begin
               if (!pu || blk) begin            // R4
                  relc_d = 16'h0000;
                  if (!ctrl_q[`C_RSTAFT])
                     op_d = 20'h00000;          // R16
                  st_d = (rel_q == 16'h0000) ? ST_IDLE : ST_REL;
               end else begin
                  op_d = op_inc;                // R24
                  if (hit)
                     st_d = ST_TRIP;            // R7
               end
            end
            ST_REL: begin
               if (pu && !blk) begin
                  st_d = ST_RUN;
               end else begin
                  relc_d = relc_q + 16'h0001;
                  if (ctrl_q[`C_CONT])
                     op_d = op_inc;             // R17
                  if (relc_d >= rel_q) begin
                     st_d = ST_IDLE;
                     op_d = 20'h00000;          // R16
                  end
               end
            end
            ST_TRIP: begin
               if (!pu || blk) begin
                  st_d = ST_IDLE;
                  op_d = 20'h00000;
               end
            end
            ST_BLK: begin
               if (!pu || !blk)
                  st_d = ST_IDLE;
            end
            default: begin
               st_d = ST_IDLE;
               op_d = 20'h00000;
            end
         endcase
      end
   end

   // Reported times, in 5 ms steps
   reg [19:0] expect_q;
   reg [19:0] remain_q;

   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         st_q      <= ST_IDLE;
         op_q      <= 20'h00000;
         relc_q    <= 16'h0000;
         start_o   <= 1'b0;
         trip_o    <= 1'b0;
         blocked_o <= 1'b0;
         expect_q  <= 20'h00000;
         remain_q  <= 20'h00000;
      end else begin
         st_q      <= st_d;
         op_q      <= op_d;
         relc_q    <= relc_d;
         start_o   <= (st_d == ST_RUN) || (st_d == ST_TRIP) ||
                      (st_d == ST_REL && ctrl_q[`C_DLYREL]);  // R15
         trip_o    <= (st_d == ST_TRIP);
         blocked_o <= (st_d == ST_BLK);
         if (eval_q) begin
            expect_q <= no_tgt ? CNT_MAX : tgt;               // R19
            // Release without continued timing is not counting down
            if ((st_d == ST_RUN || (st_d == ST_REL && ctrl_q[`C_CONT])) &&
                !no_tgt && tgt > op_d)
               remain_q <= tgt - op_d;                       // R18
            else
               remain_q <= 20'h00000;
         end
      end
   end

   // Register reads; ratios converted from Q8 to 0.01 steps
   wire [3:0]  ridx  = reg_addr_i - `A_RATIO0;
   wire [23:0] r_pct = ratio_q[ridx[1:0]] * `PCT_FULL;

   always @(posedge clk_sys_i) begin
      if (reset_i)
         reg_rdata_o <= 32'h00000000;
      else if (reg_rd_i) begin
         case (reg_addr_i)
            `A_CTRL:   reg_rdata_o <= {26'h0000000, ctrl_q};
            `A_USET:   reg_rdata_o <= {16'h0000, uset_q};
            `A_DT:     reg_rdata_o <= {12'h000, dt_q};
            `A_DIAL:   reg_rdata_o <= {16'h0000, dial_q};
            `A_EXPON:  reg_rdata_o <= {16'h0000, expon_q};
            `A_REL:    reg_rdata_o <= {16'h0000, rel_q};
            `A_UNPRIM: reg_rdata_o <= {16'h0000, unprim_q};
            `A_STATUS: reg_rdata_o <= {26'h0000000, inv_inf_q, pu, blk_cyc_q,
                                       blocked_o, trip_o, start_o};
            `A_EXPECT: reg_rdata_o <= {12'h000, expect_q};
            `A_REMAIN: reg_rdata_o <= {12'h000, remain_q};
            4'hb, 4'hc, 4'hd, 4'he:
                       reg_rdata_o <= {16'h0000, r_pct[23:8]};   // R20
            `A_PRIM:   reg_rdata_o <= prim_q;
            default:   reg_rdata_o <= 32'h00000000;
         endcase
      end else
         reg_rdata_o <= 32'h00000000;
   end

endmodule // overvoltage_trip_timing

// file: sim/ov_front_end.sv
// Far-side model: measurement front end and blocking matrix.
// Assumes commands from the bench; outputs are registered on the system clock.
`timescale 1ns/1ps
module ov_front_end (
   // Clock
   input  wire        clk_sys_i,
   // Commands
   input  wire [15:0] level_i,
   input  wire [1:0]  nphase_i,
   input  wire [15:0] sup_i,
   input  wire        blk_i,
   // Towards the stage
   output reg  [15:0] meas_a_o,
   output reg  [15:0] meas_b_o,
   output reg  [15:0] meas_c_o,
   output reg  [15:0] meas_s_o,
   output reg         block_o
);
   // Phases beyond the commanded count stay at nominal
   always @(posedge clk_sys_i) begin
      meas_a_o <= (nphase_i >= 2'h1) ? level_i : 16'h2710;
      meas_b_o <= (nphase_i >= 2'h2) ? level_i : 16'h2710;
      meas_c_o <= (nphase_i == 2'h3) ? level_i : 16'h2710;
      meas_s_o <= sup_i;
      // Bench raises blocking at phase 10 of a cycle, far ahead of any delay end
      block_o  <= blk_i;
   end
endmodule // ov_front_end

// file: sim/ov_trip_props.sv
// Port-level checks of the overvoltage trip stage.
// Assumes the stage's register map and one 200 MHz clock domain.
`timescale 1ns/1ps
`include "ov_trip_defs.vh"
module ov_trip_props #(
   parameter integer CYCLE_CLKS = 50
) (
   input wire        clk_sys_i,
   input wire        reset_i,
   input wire [3:0]  reg_addr_i,
   input wire        reg_rd_i,
   input wire [31:0] reg_rdata_o,
   input wire        block_i,
   input wire        start_o,
   input wire        trip_o,
   input wire        blocked_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   logic [3:0] blk_run_q;
   // Saturating run length of a steady blocking input
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !block_i) blk_run_q <= 4'h0;
      else if (blk_run_q != 4'hf) blk_run_q <= blk_run_q + 4'h1;
   end
   sequence s_read_status;
      reg_rd_i && reg_addr_i == `A_STATUS;
   endsequence
   sequence s_out_change;
      !$stable({start_o, trip_o, blocked_o});
   endsequence
   a_reset_clear: assert property (disable iff (1'b0)
      reset_i |=> !start_o && !trip_o && !blocked_o) else $error("outputs not clear");
   a_rdata_idle: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i))
      else $error("read data outside read slot");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 4'h7 |=> reg_rdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_status_mirror: assert property (s_read_status |=>
      reg_rdata_o[2:0] == $past({blocked_o, trip_o, start_o})) else $error("status mismatch");
   a_start_blocked_excl: assert property (!(start_o && blocked_o))
      else $error("start and blocked together");
   a_trip_with_start: assert property (trip_o |-> start_o)
      else $error("trip without start");
   a_eval_spacing: assert property (s_out_change |=> $stable({start_o, trip_o, blocked_o})[*8])
      else $error("outputs changed between cycles");
   a_block_no_start: assert property ($rose(start_o) |-> blk_run_q < 4'hc)
      else $error("start despite steady block");
   a_remain_idle: assert property (reg_rd_i && reg_addr_i == `A_REMAIN && !start_o
      |=> reg_rdata_o == 32'h0) else $error("remaining time while idle");
endmodule // ov_trip_props

bind overvoltage_trip_timing ov_trip_props #(.CYCLE_CLKS(CYCLE_CLKS)) i_props (
   .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .block_i(block_i), .start_o(start_o), .trip_o(trip_o),
   .blocked_o(blocked_o));

// file: sim/tb_top.sv
// Self-checking bench for the overvoltage trip stage.
// Assumes a shortened 200-clock processing cycle; checks sit at phase 10 of each cycle.
`timescale 1ns/1ps
`include "ov_trip_defs.vh"
module tb_top;
   // Six divider jobs of 32 clocks each must fit into one cycle
   localparam integer CYC = 200;
   typedef struct packed {logic [5:0] ctrl; logic [19:0] dt; logic [15:0] lvl;
      logic [1:0] nph; logic blk; logic [4:0] n; logic [2:0] ev;} row_t;
   row_t        rows [11];
   logic [3:0]  da [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf, 4'h8};
   logic [31:0] dv [10] = '{32'h16, 32'h2904, 32'h8, 32'h5, 32'h64, 32'hc, 32'h4e20, 32'h0,
      32'h33450, 32'h20};
   logic        clk_sys_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [15:0] level = 16'h2710;
   logic [15:0] sup = 16'h2710;
   logic [1:0]  nph = 2'h3;
   logic        blk = 1'b0;
   logic [7:0]  ph = 8'h0;
   logic [31:0] r1, r2;
   wire  [31:0] reg_rdata_o;
   wire  [15:0] meas_a, meas_b, meas_c, meas_s;
   wire         block, start_o, trip_o, blocked_o;
   int          fails = 0;
   int          compares = 0;
   int          i;

   initial forever #2.5 clk_sys_i = ~clk_sys_i;
   // Phase within the processing cycle; checks and stimulus sit at phase 10
   always @(posedge clk_sys_i) ph <= (reset_i || ph == CYC - 1) ? 8'h0 : ph + 8'h1;

   ov_front_end i_fe (.clk_sys_i(clk_sys_i), .level_i(level), .nphase_i(nph), .sup_i(sup),
      .blk_i(blk), .meas_a_o(meas_a), .meas_b_o(meas_b), .meas_c_o(meas_c),
      .meas_s_o(meas_s), .block_o(block));
   overvoltage_trip_timing #(.CYCLE_CLKS(CYC)) i_dut (.clk_sys_i(clk_sys_i),
      .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .meas_a_i(meas_a), .meas_b_i(meas_b), .meas_c_i(meas_c), .meas_s_i(meas_s),
      .block_i(block), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
   endtask
   // Each step ends at the next phase 10, well clear of output updates
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         while (ph != 8'd10) @(posedge clk_sys_i);
      end
   endtask
   task automatic rst();
      @(posedge clk_sys_i);
      reset_i <= 1'b1;
      level <= 16'h2710;
      blk <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
   endtask
   // Pick-up, drop for three cycles, pick-up again; trip compared with exp_trip after n more cycles
   task automatic relcase(input logic [5:0] c, input int n, input logic exp_trip);
      rst();
      wr(`A_DT, 32'h4);
      wr(`A_CTRL, {26'h0, c});
      step(1);
      level <= 16'h2af8;
      step(2);
      level <= 16'h2710;
      step(3);
      level <= 16'h2af8;
      step(n);
      chk({31'h0, trip_o}, {31'h0, exp_trip});
   endtask
   task automatic final_report();
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #250000;
      fails++;
      final_report();
   end

   initial begin
      rows = '{
         '{6'h16, 20'h0, 16'h2af8, 2'h1, 1'b0, 5'd1, 3'h3},
         '{6'h16, 20'h2, 16'h2af8, 2'h1, 1'b0, 5'd2, 3'h1},
         '{6'h16, 20'h2, 16'h2af8, 2'h1, 1'b0, 5'd3, 3'h3},
         '{6'h16, 20'h8, 16'h2af8, 2'h1, 1'b1, 5'd1, 3'h4},
         '{6'h16, 20'h0, 16'h2904, 2'h3, 1'b0, 5'd2, 3'h0},
         '{6'h26, 20'h0, 16'h2af8, 2'h1, 1'b0, 5'd1, 3'h0},
         '{6'h26, 20'h0, 16'h2af8, 2'h2, 1'b0, 5'd1, 3'h3},
         '{6'h36, 20'h0, 16'h2af8, 2'h2, 1'b0, 5'd1, 3'h0},
         '{6'h36, 20'h0, 16'h2af8, 2'h3, 1'b0, 5'd1, 3'h3},
         '{6'h17, 20'h0, 16'h5208, 2'h1, 1'b0, 5'd3, 3'h1},
         '{6'h17, 20'h0, 16'h5208, 2'h1, 1'b0, 5'd20, 3'h3}};
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      // Primary pick-up is only ready after the first full divider round
      step(3);
      for (i = 0; i < 10; i++) begin
         rd(da[i], r1);
         chk(r1, dv[i]);
      end
      wr(`A_STATUS, 32'hff);
      wr(4'h7, 32'hff);
      rd(`A_STATUS, r1);
      chk(r1, 32'h20);
      level <= 16'h5208;
      nph <= 2'h1;
      sup <= 16'h2904;
      step(2);
      rd(`A_RATIO0, r1);
      chk(r1, 32'hc8);
      rd(4'he, r1);
      chk(r1, 32'h64);
      for (i = 0; i < 11; i++) begin
         rst();
         wr(`A_CTRL, {26'h0, rows[i].ctrl});
         wr(`A_DT, {12'h0, rows[i].dt});
         step(1);
         level <= rows[i].lvl;
         nph <= rows[i].nph;
         blk <= rows[i].blk;
         step(rows[i].n);
         chk({29'h0, blocked_o, trip_o, start_o}, {29'h0, rows[i].ev});
      end
      rd(`A_EXPECT, r1);
      chk(r1, 32'ha);
      level <= 16'h3d86;
      step(2);
      rd(`A_EXPECT, r1);
      chk(r1, 32'h14);
      nph <= 2'h1;
      rst();
      wr(`A_DT, 32'h64);
      wr(`A_CTRL, 32'h14);
      step(1);
      rd(`A_REMAIN, r1);
      chk(r1, 32'h0);
      level <= 16'h2af8;
      step(2);
      rd(`A_REMAIN, r1);
      chk(r1, 32'h63);
      step(1);
      rd(`A_REMAIN, r2);
      chk(r2, r1 - 32'h1);
      level <= 16'h283c;
      step(3);
      chk({31'h0, start_o}, 32'h1);
      level <= 16'h2774;
      step(2);
      chk({31'h0, start_o}, 32'h0);
      rst();
      wr(`A_DT, 32'h64);
      step(1);
      level <= 16'h2af8;
      step(2);
      level <= 16'h2710;
      step(6);
      chk({30'h0, trip_o, start_o}, 32'h1);
      step(10);
      chk({30'h0, trip_o, start_o}, 32'h0);
      rst();
      wr(`A_DT, 32'h64);
      wr(`A_REL, 32'h0);
      step(1);
      level <= 16'h2af8;
      step(2);
      blk <= 1'b1;
      step(1);
      chk({31'h0, start_o}, 32'h0);
      step(2);
      chk({31'h0, blocked_o}, 32'h1);
      relcase(6'h1e, 2, 1'b1);
      relcase(6'h12, 4, 1'b0);
      relcase(6'h16, 4, 1'b1);
      final_report();
   end
endmodule // tb_top
